// ### src/pump_defines.svh
// Purpose: constants for the fluid level pump controller
// Assumes: 25 MHz pclk, levels in whole percent
// Notes:   times in 0.1 s ticks unless named otherwise
`ifndef PUMP_DEFINES_SVH
`define PUMP_DEFINES_SVH

// ----------------------------------------------------------
// timing
// ----------------------------------------------------------
`define CLK_HZ        25000000
`define TICK_MS       100
`define MS_PER_S      1000
`define TICKS_PER_S   10

// ----------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------
`define OFS_CTRL      12'h000
`define OFS_CFGA0     12'h010
`define OFS_CFGB0     12'h014
`define OFS_CFG_STEP  12'h008
`define OFS_SRC_SEL   12'h028
`define OFS_TANK_CAP  12'h02C
`define OFS_VOLUME    12'h030
`define OFS_STATE     12'h038
`define OFS_IRQ_STAT  12'h03C
`define OFS_IRQ_MASK  12'h040

// ----------------------------------------------------------
// reset values
// ----------------------------------------------------------
`define RST_START     7'h14
`define RST_STOP      7'h50
`define RST_DELAY_S   4'h1
`define RST_SLOPE     4'h2
`define RST_CHECK     14'h0258
`define RST_FCLASS    2'h0
`define RST_SRC       4'h0
`define RST_CAP       16'h0000
`define RST_CTRL      6'h07

// ----------------------------------------------------------
// misc
// ----------------------------------------------------------
`define PCT_FULL      8'h64
`define NUM_SRC       4'hB
`define NUM_MULTI     4'h3
`define CH_FUEL       0
`define CH_EXH        1
`define CH_GEN        2

`endif

// ### src/pump_pkg.sv
// Purpose: shared types of the fluid level pump controller
// Assumes: no defines included, all widths and codes are literals
// Notes:   one config struct per pump channel
package pump_pkg;

    typedef logic [6:0]  pct_t;
    typedef logic [1:0]  fail_class_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_DELAY = 4'b0010,
        ST_RUN   = 4'b0100,
        ST_FAULT = 4'b1000
    } pump_state_e;

    typedef struct packed {
        logic         enable;
        pct_t         start_pct;
        pct_t         stop_pct;
        logic [3:0]   delay_s;
        logic [3:0]   slope_pct;
        logic [13:0]  check_ticks;
        fail_class_t  fail_class;
    } chan_cfg_s;

endpackage

// ### src/pump_channel.sv
// Purpose: one level controlled pump with fill supervision
// Assumes: tick is a one-cycle pulse every 0.1 s
// Notes:   a fill fault holds the relay off until cleared, unless force_on drives it on
`include "pump_defines.svh"
module pump_channel (
    input  wire logic              pclk,      // clock
    input  wire logic              presetn,   // async reset, low
    input  wire logic              ce,        // clock enable
    input  wire logic              tick,      // 0.1 s pulse
    input  wire pump_pkg::chan_cfg_s cfg,     // settings
    input  wire pump_pkg::pct_t    level,     // level in percent
    input  wire logic              level_ok,  // level is usable
    input  wire logic              force_on,  // external force
    input  wire logic              fault_clr, // release fault
    output logic                   relay,     // pump relay
    output logic                   fault,     // fill fault held
    output logic                   fill_evt   // fill alarm pulse
);
    import pump_pkg::*;

    pump_state_e  state_q;
    logic [13:0]  cnt_q;
    pct_t         base_q;
    logic         below_start;
    logic         above_stop;
    logic         risen;
    logic [13:0]  cnt_nx;
    logic [7:0]   delay_ticks;

    assign below_start = level < cfg.start_pct;
    assign above_stop  = level > cfg.stop_pct;
    assign risen = {1'b0, level} >= ({1'b0, base_q} + {4'h0, cfg.slope_pct});
    assign cnt_nx = cnt_q + 14'h0001;
    assign delay_ticks = 8'(cfg.delay_s * `TICKS_PER_S);

    // ----------------------------------------------------------
    // sequence
    // ----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q  <= ST_IDLE;
            cnt_q    <= 14'h0000;
            base_q   <= 7'h00;
            fill_evt <= 1'b0;
        end else if (ce) begin
            fill_evt <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    cnt_q <= 14'h0000;
                    if (cfg.enable && level_ok && below_start) begin
                        state_q <= ST_DELAY; // RULE_01
                    end
                end
                ST_DELAY: begin
                    if (!cfg.enable || !level_ok || !below_start) begin
                        state_q <= ST_IDLE;
                    end else if (tick) begin
                        cnt_q <= cnt_nx;
                        if (cnt_nx >= {6'h00, delay_ticks}) begin
                            state_q <= ST_RUN; // RULE_04
                            base_q  <= level;
                            cnt_q   <= 14'h0000;
                        end
                    end
                end
                ST_RUN: begin
                    if (!cfg.enable || !level_ok || above_stop) begin
                        state_q <= ST_IDLE; // RULE_02
                    end else if (risen) begin
                        base_q <= level; // RULE_07
                        cnt_q  <= 14'h0000;
                    end else if (tick) begin
                        cnt_q <= cnt_nx;
                        if (cnt_nx >= cfg.check_ticks) begin
                            state_q  <= ST_FAULT; // RULE_05 RULE_06
                            fill_evt <= 1'b1;
                        end
                    end
                end
                ST_FAULT: begin
                    if (fault_clr) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // between the points only the fill fault, disable, level_ok and force_on branches change the relay
    assign relay = (state_q == ST_RUN) || force_on; // RULE_03 RULE_10
    assign fault = state_q == ST_FAULT;

endmodule // pump_channel

// ### src/pump_ctrl.sv
// Purpose: fuel, exhaust fluid and generic fluid pump control
// Assumes: levels arrive synchronous to pclk in whole percent
// Notes:   registers over APB, one level interrupt
//
// Summary of operation
// RULE_01 - relay on when level below start
// RULE_02 - relay off when level above stop
// RULE_03 - relay holds between the two points
// RULE_04 - start condition must last start delay
// RULE_05 - no rise in check time drops relay
// RULE_06 - check time and fail class per pump
// RULE_07 - required rise is the fill slope
// RULE_08 - link supplies exhaust level, else generic; code holds the exhaust pump idle while the link is down
// RULE_09 - generic level from selectable analogue source
// RULE_10 - external command forces relay on
// RULE_11 - limit-type outputs raise no energise alarm
// RULE_12 - fuel volume from tank capacity and level
`include "pump_defines.svh"
module pump_ctrl #(
    parameter int TICK_CYCLES = `CLK_HZ / `MS_PER_S * `TICK_MS
) (
    input  wire logic              pclk,        // apb clock
    input  wire logic              presetn,     // async reset, low
    input  wire logic              ce,          // clock enable
    input  wire logic              psel,        // apb select
    input  wire logic              penable,     // apb enable
    input  wire logic              pwrite,      // apb direction
    input  wire logic [11:0]       paddr,       // apb byte address
    input  wire logic [31:0]       pwdata,      // apb write data
    output logic [31:0]            prdata,      // apb read data
    output logic                   pready,      // apb ready
    output logic                   pslverr,     // apb error
    input  wire pump_pkg::pct_t    fuel_level,  // fuel level
    input  wire pump_pkg::pct_t    exhaust_fluid_level, // link level
    input  wire logic              engine_data_link_ok, // link valid
    input  wire pump_pkg::pct_t    multi_level [3], // multi-inputs
    input  wire pump_pkg::pct_t    ext_level [8],   // ext analogue
    input  wire logic [2:0]        force_cmd,   // force relay on
    output logic [2:0]             pump_relay,  // relay drives
    output logic [2:0]             fill_alarm,  // fault held
    output pump_pkg::fail_class_t  alarm_class [3], // class of alarm
    output logic [22:0]            fuel_volume, // capacity * level / 100
    output logic                   irq          // interrupt, high
);
    import pump_pkg::*;

    localparam int TW = $clog2(TICK_CYCLES + 1);

    // ----------------------------------------------------------
    // registers
    // ----------------------------------------------------------
    logic [5:0]   ctrl_q;     // [2:0] enable, [5:3] limit type
    chan_cfg_s    cfg_q [3];
    logic [3:0]   src_q;
    logic [15:0]  cap_q;
    logic [5:0]   irq_stat_q; // [2:0] fill, [5:3] energise
    logic [5:0]   irq_mask_q;
    logic [22:0]  vol_q;
    logic [31:0]  rdata_q;
    logic         err_q;

    logic         acc;
    logic         wr;
    logic [11:0]  a;
    logic [31:0]  rd_d;
    logic         mapped;

    assign acc = psel && penable;
    assign wr  = acc && pwrite;
    assign a   = paddr;
    assign pready  = 1'b1;
    assign prdata  = rdata_q;
    assign pslverr = acc && !mapped;

    // ----------------------------------------------------------
    // tick generator
    // ----------------------------------------------------------
    logic [TW-1:0] tcnt_q;
    logic          tick;

    assign tick = tcnt_q == TW'(TICK_CYCLES - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcnt_q <= '0;
        end else if (ce) begin
            tcnt_q <= tick ? '0 : tcnt_q + TW'(1);
        end
    end

    // ----------------------------------------------------------
    // level sources
    // ----------------------------------------------------------
    pct_t  lvl [3];
    logic  lvl_ok [3];

    always_comb begin
        lvl[`CH_FUEL]    = fuel_level;
        lvl_ok[`CH_FUEL] = 1'b1;
        lvl[`CH_EXH]     = exhaust_fluid_level;
        lvl_ok[`CH_EXH]  = engine_data_link_ok; // RULE_08
        lvl_ok[`CH_GEN]  = src_q < `NUM_SRC;
        if (src_q < `NUM_MULTI) begin
            lvl[`CH_GEN] = multi_level[src_q[1:0]]; // RULE_09
        end else if (src_q < `NUM_SRC) begin
            lvl[`CH_GEN] = ext_level[3'(src_q - `NUM_MULTI)];
        end else begin
            lvl[`CH_GEN] = 7'h00;
        end
    end

    // ----------------------------------------------------------
    // pump channels
    // ----------------------------------------------------------
    logic [2:0] relay;
    logic [2:0] fault;
    logic [2:0] fill_evt;
    logic [2:0] relay_q;
    logic [2:0] fclr;

    assign fclr = wr && (a == `OFS_IRQ_STAT) ? pwdata[2:0] : 3'h0;

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_ch
            pump_channel u_ch (
                .pclk      (pclk),
                .presetn   (presetn),
                .ce        (ce),
                .tick      (tick),
                .cfg       ({ctrl_q[g], cfg_q[g][37:0]}),
                .level     (lvl[g]),
                .level_ok  (lvl_ok[g]),
                .force_on  (force_cmd[g]), // RULE_10
                .fault_clr (fclr[g]),
                .relay     (relay[g]),
                .fault     (fault[g]),
                .fill_evt  (fill_evt[g])
            );
            assign alarm_class[g] = cfg_q[g].fail_class; // RULE_06
        end
    endgenerate

    assign fill_alarm = fault;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            relay_q <= 3'h0;
        end else if (ce) begin
            relay_q <= relay;
        end
    end

    assign pump_relay = relay_q;

    // ----------------------------------------------------------
    // interrupt status, set wins over clear
    // ----------------------------------------------------------
    logic [5:0] ev;

    // energise event only for outputs not of limit type
    assign ev = {relay & ~relay_q & ~ctrl_q[5:3], fill_evt}; // RULE_11

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 6'h00;
        end else if (ce) begin
            if (wr && (a == `OFS_IRQ_STAT)) begin
                irq_stat_q <= (irq_stat_q & ~pwdata[5:0]) | ev;
            end else begin
                irq_stat_q <= irq_stat_q | ev;
            end
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ----------------------------------------------------------
    // fuel volume
    // ----------------------------------------------------------
    logic [22:0] prod;

    // registered so the divider has a full cycle to settle
    assign prod = cap_q * lvl[`CH_FUEL];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vol_q <= 23'h000000;
        end else if (ce) begin
            vol_q <= 23'(prod / 23'(`PCT_FULL)); // RULE_12
        end
    end

    assign fuel_volume = vol_q;

    // ----------------------------------------------------------
    // register writes
    // ----------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= `RST_CTRL;
            src_q      <= `RST_SRC;
            cap_q      <= `RST_CAP;
            irq_mask_q <= 6'h00;
        end else if (ce && wr) begin
            if (a == `OFS_CTRL) begin
                ctrl_q <= pwdata[5:0];
            end
            if (a == `OFS_SRC_SEL) begin
                src_q <= pwdata[3:0];
            end
            if (a == `OFS_TANK_CAP) begin
                cap_q <= pwdata[15:0];
            end
            if (a == `OFS_IRQ_MASK) begin
                irq_mask_q <= pwdata[5:0];
            end
        end
    end

    generate
        for (g = 0; g < 3; g++) begin : g_cfg
            localparam logic [11:0] OA = 12'(`OFS_CFGA0 + g * `OFS_CFG_STEP);
            localparam logic [11:0] OB = 12'(`OFS_CFGB0 + g * `OFS_CFG_STEP);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_q[g].start_pct   <= `RST_START;
                    cfg_q[g].stop_pct    <= `RST_STOP;
                    cfg_q[g].delay_s     <= `RST_DELAY_S;
                    cfg_q[g].slope_pct   <= `RST_SLOPE;
                    cfg_q[g].check_ticks <= `RST_CHECK;
                    cfg_q[g].fail_class  <= `RST_FCLASS;
                end else if (ce && wr && (a == OA)) begin
                    cfg_q[g].start_pct <= pwdata[6:0];
                    cfg_q[g].stop_pct  <= pwdata[14:8];
                    cfg_q[g].delay_s   <= pwdata[19:16];
                    cfg_q[g].slope_pct <= pwdata[27:24];
                end else if (ce && wr && (a == OB)) begin
                    cfg_q[g].check_ticks <= pwdata[13:0];
                    cfg_q[g].fail_class  <= pwdata[17:16];
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------
    // register reads
    // ----------------------------------------------------------
    always_comb begin
        rd_d   = 32'h00000000;
        mapped = 1'b1;
        unique case (a)
            `OFS_CTRL:     rd_d = {26'h0, ctrl_q};
            `OFS_SRC_SEL:  rd_d = {28'h0, src_q};
            `OFS_TANK_CAP: rd_d = {16'h0, cap_q};
            `OFS_VOLUME:   rd_d = {9'h0, vol_q};
            `OFS_STATE:    rd_d = {25'h0, fault, 1'b0, relay_q};
            `OFS_IRQ_STAT: rd_d = {26'h0, irq_stat_q};
            `OFS_IRQ_MASK: rd_d = {26'h0, irq_mask_q};
            default: begin
                mapped = 1'b0;
                for (int i = 0; i < 3; i++) begin
                    if (a == 12'(`OFS_CFGA0 + i * `OFS_CFG_STEP)) begin
                        mapped = 1'b1;
                        rd_d = {4'h0, cfg_q[i].slope_pct,
                                4'h0, cfg_q[i].delay_s,
                                1'b0, cfg_q[i].stop_pct,
                                1'b0, cfg_q[i].start_pct};
                    end
                    if (a == 12'(`OFS_CFGB0 + i * `OFS_CFG_STEP)) begin
                        mapped = 1'b1;
                        rd_d = {14'h0, cfg_q[i].fail_class,
                                2'h0, cfg_q[i].check_ticks};
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h00000000;
        end else if (ce && psel && !penable && !pwrite) begin
            rdata_q <= rd_d;
        end
    end

endmodule // pump_ctrl

// ### tb/pump_ctrl_props.sv
// Purpose: port level checks of the pump controller
// Assumes: stop point stays below 100 %, start delay at least 1 s
// Notes:   bound into pump_ctrl
module pump_ctrl_props (
    input wire logic                  pclk,        // clock
    input wire logic                  presetn,     // async reset, low
    input wire logic                  ce,          // clock enable
    input wire logic                  psel,        // apb select
    input wire logic                  penable,     // apb enable
    input wire logic [11:0]           paddr,       // apb address
    input wire logic                  pready,      // apb ready
    input wire logic                  pslverr,     // apb error
    input wire pump_pkg::pct_t        fuel_level,  // fuel level
    input wire logic                  engine_data_link_ok, // link valid
    input wire logic [2:0]            force_cmd,   // force relay on
    input wire logic [2:0]            pump_relay,  // relay drives
    input wire logic [2:0]            fill_alarm,  // fault held
    input wire logic [22:0]           fuel_volume  // tank volume
);
    timeunit 1ns;
    timeprecision 1ps;
    import pump_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // --------------------------------------------------------
    // sequences
    // --------------------------------------------------------
    sequence s_full_idle;
        (fuel_level == 7'h64 && !force_cmd[0]) ##1 (!force_cmd[0]) [*2];
    endsequence
    a_ready_always: assert property (pready)
        else $error("pready low");
    a_err_mapped: assert property (
        psel && penable && paddr == 12'h000 |-> !pslverr)
        else $error("mapped err");
    a_err_unmapped: assert property (
        psel && penable && paddr == 12'h004 |-> pslverr)
        else $error("unmapped no err");
    a_force_all_on: assert property (
        (ce && force_cmd == 3'b111) [*3] |-> pump_relay == 3'b111)
        else $error("forced relay not on");
    a_fault_drops_relay: assert property (
        (ce && fill_alarm[0] && !force_cmd[0]) [*3] |-> !pump_relay[0])
        else $error("relay on in fault");
    a_full_tank_off: assert property (
        (ce && fuel_level == 7'h64 && !force_cmd[0]) [*3] |-> !pump_relay[0])
        else $error("relay on above stop point");
    a_no_instant_start: assert property (s_full_idle |-> !$rose(pump_relay[0]))
        else $error("relay start too early");
    a_link_down_idle: assert property (
        (ce && !engine_data_link_ok && !force_cmd[1]) [*3] |-> !pump_relay[1])
        else $error("relay on, link down");
    a_volume_empty: assert property (
        (ce && fuel_level == 7'h00) [*3] |-> fuel_volume == 23'h000000)
        else $error("volume not zero");
endmodule // pump_ctrl_props

bind pump_ctrl pump_ctrl_props u_props (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .fuel_level(fuel_level), .engine_data_link_ok(engine_data_link_ok),
    .force_cmd(force_cmd), .pump_relay(pump_relay),
    .fill_alarm(fill_alarm), .fuel_volume(fuel_volume)
);

// ### tb/pump_partner.sv
// Purpose: tanks, level sensors and engine data link around the pumps
// Assumes: a filling pump adds 1 % per RATE cycles
// Notes:   only the selected generic source shows the generic tank
module pump_partner #(
    parameter int RATE = 8
) (
    input  wire logic       pclk,       // clock
    input  wire logic       presetn,    // reset, low
    input  wire logic [2:0] relay,      // relays from the controller
    input  wire logic [2:0] fill_en,    // pump actually delivers
    input  wire logic [2:0] load,       // overwrite tank level
    input  wire pump_pkg::pct_t load_val, // level to load
    input  wire logic       link_up,    // link delivers data
    input  wire logic [3:0] gsrc,       // source carrying generic tank
    output pump_pkg::pct_t  fuel_level, // fuel sensor
    output pump_pkg::pct_t  exhaust_fluid_level, // link level
    output logic            engine_data_link_ok, // link valid
    output pump_pkg::pct_t  multi_level [3], // multi-inputs
    output pump_pkg::pct_t  ext_level [8]    // ext analogue
);
    timeunit 1ns;
    timeprecision 1ps;
    import pump_pkg::*;
    pct_t tank [3];
    int   cnt  [3];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tank <= '{7'h32, 7'h32, 7'h32};
            cnt  <= '{0, 0, 0};
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (load[i]) begin
                    tank[i] <= load_val;
                end else if (relay[i] && fill_en[i]) begin
                    cnt[i] <= (cnt[i] == RATE - 1) ? 0 : cnt[i] + 1;
                    if (cnt[i] == RATE - 1 && tank[i] < 7'h64) begin
                        tank[i] <= tank[i] + 7'h01;
                    end
                end
            end
        end
    end
    assign fuel_level          = tank[0];
    // stale data must not look valid once the link drops
    assign engine_data_link_ok = link_up;
    assign exhaust_fluid_level = link_up ? tank[1] : ~tank[1];
    for (genvar g = 0; g < 3; g++) begin : g_multi
        assign multi_level[g] = (gsrc == 4'(g)) ? tank[2] : 7'h64;
    end
    for (genvar g = 0; g < 8; g++) begin : g_ext
        assign ext_level[g] = (gsrc == 4'(g + 3)) ? tank[2] : 7'h64;
    end
endmodule // pump_partner

// ### tb/testbench.sv
// Purpose: self-checking bench of the pump controller
// Assumes: tick every 2 cycles, so 1 s is 20 cycles
// Notes:   ce tied high
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import pump_pkg::*;
    typedef struct packed {logic [3:0] src; logic [3:0] gs; logic on;} row_s;
    localparam row_s ROWS [13] = '{
        '{4'h0, 4'h0, 1'b1}, '{4'h1, 4'h1, 1'b1}, '{4'h2, 4'h2, 1'b1},
        '{4'h3, 4'h3, 1'b1}, '{4'h4, 4'h4, 1'b1}, '{4'h5, 4'h5, 1'b1},
        '{4'h6, 4'h6, 1'b1}, '{4'h7, 4'h7, 1'b1}, '{4'h8, 4'h8, 1'b1},
        '{4'h9, 4'h9, 1'b1}, '{4'hA, 4'hA, 1'b1}, '{4'h3, 4'h4, 1'b0},
        '{4'hB, 4'hB, 1'b0}};
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, irq, e, link_ok, link_up = 1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [2:0]  force_cmd = '0, pump_relay, fill_alarm;
    logic [2:0]  fill_en = '0, load = '0;
    logic [3:0]  gsrc = '0;
    logic [22:0] fuel_volume;
    pct_t        lv = 7'h32, fuel, exh, multi [3], ext [8];
    fail_class_t alarm_class [3];
    int          err_total = 0, checks = 0;
    always #20 pclk = ~pclk;
    pump_ctrl #(.TICK_CYCLES(2)) dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fuel_level(fuel), .exhaust_fluid_level(exh),
        .engine_data_link_ok(link_ok), .multi_level(multi), .ext_level(ext),
        .force_cmd(force_cmd), .pump_relay(pump_relay),
        .fill_alarm(fill_alarm), .alarm_class(alarm_class),
        .fuel_volume(fuel_volume), .irq(irq));
    pump_partner #(.RATE(8)) u_far (
        .pclk(pclk), .presetn(presetn), .relay(pump_relay), .fill_en(fill_en),
        .load(load), .load_val(lv), .link_up(link_up), .gsrc(gsrc),
        .fuel_level(fuel), .exhaust_fluid_level(exh),
        .engine_data_link_ok(link_ok), .multi_level(multi), .ext_level(ext));
    // --------------------------------------------------------
    // tasks
    // --------------------------------------------------------
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        e  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // load lands at the second edge
    task automatic lvl(input logic [2:0] m, input pct_t v);
        @(posedge pclk);
        load <= m;
        lv   <= v;
        @(posedge pclk);
        load <= 3'b000;
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        err_total++;
        print_verdict;
    end
    // --------------------------------------------------------
    // sequence
    // --------------------------------------------------------
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h010, '0);
        chk(rd, 32'h0201_5014);
        apb(1'b0, 12'h014, '0);
        chk(rd, 32'h0000_0258);
        apb(1'b0, 12'h004, '0);
        chk(rd, 32'h0);
        chk(e, 1'b1);
        for (int i = 0; i < 13; i++) begin
            apb(1'b1, 12'h028, {28'h0, ROWS[i].src});
            gsrc <= ROWS[i].gs;
            lvl(3'b100, 7'h0A);
            wt(30);
            chk(pump_relay[2], ROWS[i].on);
            lvl(3'b100, 7'h64);
            wt(6);
        end
        apb(1'b1, 12'h040, 32'h3F);
        lvl(3'b001, 7'h14);
        wt(40);
        chk(pump_relay[0], 1'b0);
        lvl(3'b001, 7'h13);
        wt(10);
        chk(pump_relay[0], 1'b0);
        wt(20);
        chk(pump_relay[0], 1'b1);
        apb(1'b0, 12'h03C, '0);
        chk({rd[3], irq}, 2'b11);
        lvl(3'b001, 7'h50);
        wt(10);
        chk(pump_relay[0], 1'b1);
        lvl(3'b001, 7'h51);
        wt(5);
        chk(pump_relay[0], 1'b0);
        lvl(3'b001, 7'h64);
        apb(1'b1, 12'h03C, 32'h3F);
        wt(2);
        chk(irq, 1'b0);
        // a working pump must not trip the short check window at the 2 % slope
        fill_en <= 3'b001;
        apb(1'b1, 12'h014, 32'h0002_0014);
        wt(1);
        chk(alarm_class[0], 2'h2);
        lvl(3'b001, 7'h0A);
        wt(130);
        chk({fill_alarm[0], pump_relay[0]}, 2'b01);
        apb(1'b1, 12'h010, 32'h0A01_5014);
        wt(70);
        chk({fill_alarm[0], pump_relay[0], irq}, 3'b101);
        fill_en <= 3'b000;
        lvl(3'b001, 7'h32);
        apb(1'b1, 12'h040, '0);
        wt(1);
        chk(irq, 1'b0);
        apb(1'b1, 12'h040, 32'h3F);
        wt(1);
        chk(irq, 1'b1);
        apb(1'b1, 12'h03C, 32'h3F);
        wt(3);
        chk({fill_alarm[0], pump_relay[0], irq}, 3'b000);
        apb(1'b1, 12'h000, 32'h0F);
        lvl(3'b001, 7'h0A);
        wt(30);
        apb(1'b0, 12'h03C, '0);
        chk({pump_relay[0], rd[3]}, 2'b10);
        lvl(3'b001, 7'h64);
        link_up <= 1'b0;
        lvl(3'b010, 7'h0A);
        wt(40);
        chk(pump_relay[1], 1'b0);
        link_up <= 1'b1;
        wt(30);
        chk(pump_relay[1], 1'b1);
        lvl(3'b111, 7'h64);
        wt(6);
        force_cmd <= 3'b111;
        wt(4);
        chk(pump_relay, 3'b111);
        force_cmd <= 3'b000;
        wt(4);
        chk(pump_relay, 3'b000);
        apb(1'b1, 12'h02C, 32'h03E8);
        lvl(3'b001, 7'h21);
        wt(3);
        chk(fuel_volume, 23'h00014A);
        apb(1'b0, 12'h030, '0);
        chk(rd, 32'h0000_014A);
        lvl(3'b001, 7'h00);
        wt(4);
        chk(fuel_volume, 23'h000000);
        print_verdict;
    end
endmodule // testbench
